//--- inc/drr_pkg.sv
// Constants, field layout and helpers for the DMA request router.
// Assumes one clock domain; all users import the whole package.
package drr_pkg;
	// Structure
	localparam int NCH = 4;
	localparam int NGEN = 2;
	localparam int NREQ = 64;
	localparam int NSYNC = 32;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NIRQ = NCH + NGEN;

	// Field layout of the channel and generator configuration words
	localparam int REQ_SEL_LSB = 0;
	localparam int REQ_SEL_W = 6;
	localparam int SYNC_EN_BIT = 16;
	localparam int POL_LSB = 17;
	localparam int POL_W = 2;
	localparam int NB_LSB = 19;
	localparam int NB_W = 5;
	localparam int SID_LSB = 24;
	localparam int SID_W = 5;
	localparam int GSEL_LSB = 0;
	localparam int GEN_EN_BIT = 16;

	// Writable bits of each configuration word
	localparam logic [DATA_W-1:0] CCFG_MASK = 32'h1fff_003f;
	localparam logic [DATA_W-1:0] GCFG_MASK = 32'h00ff_001f;
	localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] CCFG_BASE = 12'h000;
	localparam logic [ADDR_W-1:0] GCFG_BASE = 12'h020;
	localparam logic [ADDR_W-1:0] CH_STAT_ADDR = 12'h080;
	localparam logic [ADDR_W-1:0] CH_CLR_ADDR = 12'h084;
	localparam logic [ADDR_W-1:0] GEN_STAT_ADDR = 12'h088;
	localparam logic [ADDR_W-1:0] GEN_CLR_ADDR = 12'h08c;
	localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 12'h090;
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h094;

	// Synchronization / trigger polarity encodings
	localparam logic [POL_W-1:0] POL_NONE = 2'h0;
	localparam logic [POL_W-1:0] POL_RISE = 2'h1;
	localparam logic [POL_W-1:0] POL_FALL = 2'h2;
	localparam logic [POL_W-1:0] POL_BOTH = 2'h3;

	localparam logic [NB_W-1:0] NB_ZERO = 5'h00;

	typedef enum logic [0:0] {
		DRR_G_IDLE = 1'b0,
		DRR_G_BUSY = 1'b1
	} drr_gst_e;

	// Edge of the selected input as chosen by the polarity field
	function automatic logic drr_edge(input logic [POL_W-1:0] pol,
		input logic prev, input logic cur);
		case (pol)
			POL_RISE: drr_edge = cur & ~prev;
			POL_FALL: drr_edge = ~cur & prev;
			POL_BOTH: drr_edge = cur ^ prev;
			default: drr_edge = 1'b0;
		endcase
	endfunction : drr_edge
endpackage : drr_pkg

//--- hw/drr_chan.sv
// One router channel: picks a request, optionally gated by a sync event.
// Assumes the configuration inputs come straight from the register file.
`timescale 1ns/1ps
module drr_chan
	import drr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic sync_enable,
	input wire logic [POL_W-1:0] sync_polarity,
	input wire logic [REQ_SEL_W-1:0] request_select,
	input wire logic [SID_W-1:0] sync_input_select,
	input wire logic [NB_W-1:0] fwd_count,
	input wire logic cfg_wr,
	input wire logic [NREQ-1:0] req_all,
	input wire logic [NSYNC-1:0] sync_in,
	input wire logic dma_ack,
	output logic dma_req,
	output logic served,
	output logic sync_ovr
);
	logic prev_r;
	logic cfg_wr_d_r;
	logic open_r;
	logic [NB_W-1:0] cnt_r;
	logic open_nxt;
	logic [NB_W-1:0] cnt_nxt;

	// Selection is purely combinational, so a new select acts at once
	wire sel_req = req_all[request_select];
	wire sel_sync = sync_in[sync_input_select];
	// Edge suppressed right after a config write: prev still holds old input
	wire sync_evt = sync_enable && !cfg_wr_d_r &&
		drr_edge(sync_polarity, prev_r, sel_sync);
	wire last_ack = open_r && served && (cnt_r == NB_ZERO);

	assign dma_req = sync_enable ? (open_r & sel_req) : sel_req;
	assign served = dma_ack & dma_req;
	// Event while the window is still open, final ack cycle included
	assign sync_ovr = sync_evt && open_r;

	// Window of forwarded requests after each sync event that finds it closed
	always_comb begin
		open_nxt = open_r;
		cnt_nxt = cnt_r;
		if (!sync_enable) begin
			open_nxt = 1'b0;
		end else if (sync_evt && !open_r) begin
			open_nxt = 1'b1;
			cnt_nxt = fwd_count;
		end else if (last_ack) begin
			open_nxt = 1'b0;
		end else if (open_r && served) begin
			cnt_nxt = cnt_r - 5'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			prev_r <= 1'b0;
			cfg_wr_d_r <= 1'b0;
			open_r <= 1'b0;
			cnt_r <= NB_ZERO;
		end else if (ce) begin
			prev_r <= sel_sync;
			cfg_wr_d_r <= cfg_wr;
			open_r <= open_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	sequence s_cfg_then_open;
		ce && cfg_wr ##1 (sync_enable && open_r);
	endsequence

	AST_ROUTE_NEW: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		s_cfg_then_open |-> dma_req == req_all[request_select])
		else $error("channel routed a stale request");
	// Sync off: straight through now, and no window left open afterwards
	AST_PASS: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		ce && !sync_enable |-> (dma_req == req_all[request_select])
		##1 !open_r)
		else $error("request not passed through");
endmodule : drr_chan

//--- hw/drr_gen.sv
// Request generator: turns each trigger taken while idle into a burst of requests.
// Assumes gen_ack pulses once per served request while req is high.
`timescale 1ns/1ps
module drr_gen
	import drr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic gen_enable,
	input wire logic [POL_W-1:0] trig_polarity,
	input wire logic [SID_W-1:0] trig_select,
	input wire logic [NB_W-1:0] generated_request_count,
	input wire logic [NSYNC-1:0] sync_in,
	input wire logic gen_ack,
	output logic gen_req,
	output logic trig_ovr
);
	drr_gst_e state_r;
	drr_gst_e state_nxt;
	logic prev_r;
	logic [NB_W-1:0] cnt_r;
	logic [NB_W-1:0] cnt_nxt;

	wire trig = sync_in[trig_select];
	wire evt = gen_enable && drr_edge(trig_polarity, prev_r, trig);
	wire busy = (state_r == DRR_G_BUSY);

	assign gen_req = busy;
	// Busy still covers the cycle of the final ack
	assign trig_ovr = evt && busy;

	// Burst sequencer; count field holds requests minus one
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			DRR_G_IDLE: begin
				if (evt) begin
					state_nxt = DRR_G_BUSY;
					cnt_nxt = generated_request_count;
				end
			end
			DRR_G_BUSY: begin
				if (gen_ack && cnt_r == NB_ZERO) begin
					state_nxt = DRR_G_IDLE;
				end else if (gen_ack) begin
					cnt_nxt = cnt_r - 5'h01;
				end
			end
			default: state_nxt = DRR_G_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_r <= DRR_G_IDLE;
			prev_r <= 1'b0;
			cnt_r <= NB_ZERO;
		end else if (ce) begin
			state_r <= state_nxt;
			prev_r <= trig;
			cnt_r <= cnt_nxt;
		end
	end

	sequence s_burst_start;
		ce && !busy && evt;
	endsequence

	AST_GEN_LOAD: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		s_burst_start |=> busy && cnt_r == $past(generated_request_count))
		else $error("burst count not loaded");
	// A trigger in the final ack cycle is refused, not a new burst
	AST_GEN_OVR: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		ce && busy && evt && gen_ack && cnt_r == NB_ZERO |=> !busy)
		else $error("final ack trigger restarted the burst");
	AST_GEN_HOLD: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		ce && busy && !gen_ack |=> busy && $stable(cnt_r))
		else $error("burst ended early");
endmodule : drr_gen

//--- hw/drr_top.sv
// What this block does
// - Writing one to a channel clear bit clears that sync overrun flag.
// - A sync overrun that meets a clear write still sets its flag.
// - Writing one to a generator clear bit clears its trigger overrun.
// - A trigger overrun that meets a clear write still sets its flag.
// - A trigger during a burst, final ack cycle included, is overrun.
// - Each trigger taken while idle yields the full programmed number of requests.
// - Each channel holds enable, polarity, request and sync selects.
// - A config write that changes the request select routes the new one.
//
// Router top: register file, channels, generators and interrupt.
// Assumes a single-cycle strobe master and synchronous inputs.
`timescale 1ns/1ps
module drr_top
	import drr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [NREQ-1:0] periph_req,
	input wire logic [NSYNC-1:0] sync_in,
	output logic [NCH-1:0] dma_req,
	input wire logic [NCH-1:0] dma_ack,
	output logic irq
);
	logic [DATA_W-1:0] ccfg_r [NCH];
	logic [DATA_W-1:0] gcfg_r [NGEN];
	logic [NCH-1:0] sovr_r;
	logic [NGEN-1:0] tovr_r;
	logic [NIRQ-1:0] irq_stat_r;
	logic [NIRQ-1:0] irq_mask_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rd_mux;

	logic [NCH-1:0] ch_ovr;
	logic [NCH-1:0] ch_served;
	logic [NCH-1:0] ch_cfg_wr;
	logic [NGEN-1:0] g_req;
	logic [NGEN-1:0] g_ovr;
	logic [NGEN-1:0] g_ack;
	logic [NREQ-1:0] req_all;

	// Address decode; only aligned words are mapped
	wire aligned = (reg_addr[1:0] == 2'h0);
	wire ccfg_hit = aligned && (reg_addr[ADDR_W-1:4] == CCFG_BASE[ADDR_W-1:4]);
	wire gcfg_hit = aligned && (reg_addr[ADDR_W-1:3] == GCFG_BASE[ADDR_W-1:3]);
	wire [1:0] ch_idx = reg_addr[3:2];
	wire [0:0] g_idx = reg_addr[2:2];
	wire ch_clr_wr = reg_wr && (reg_addr == CH_CLR_ADDR);
	wire g_clr_wr = reg_wr && (reg_addr == GEN_CLR_ADDR);
	wire irq_rd = reg_rd && (reg_addr == IRQ_STAT_ADDR);
	wire mask_wr = reg_wr && (reg_addr == IRQ_MASK_ADDR);

	// Clear masks from the written data, one bit per channel or generator
	wire [NCH-1:0] ch_clr = ch_clr_wr ? reg_wdata[NCH-1:0] : '0;
	wire [NGEN-1:0] g_clr = g_clr_wr ? reg_wdata[NGEN-1:0] : '0;
	// Set after clear so a coincident event from any channel survives
	wire [NCH-1:0] sovr_nxt = (sovr_r & ~ch_clr) | ch_ovr;
	wire [NGEN-1:0] tovr_nxt = (tovr_r & ~g_clr) | g_ovr;
	wire [NIRQ-1:0] irq_evt = {g_ovr, ch_ovr};
	wire [NIRQ-1:0] irq_clr = irq_rd ? irq_stat_r : '0;
	wire [NIRQ-1:0] irq_nxt = (irq_stat_r & ~irq_clr) | irq_evt;

	// Generator outputs occupy the lowest request indices
	assign req_all = {periph_req[NREQ-1:NGEN], g_req};
	assign irq = |(irq_stat_r & irq_mask_r);
	assign reg_rdata = rdata_r;

	// Read mux; unmapped addresses read as zero
	always_comb begin
		rd_mux = RESET_WORD;
		if (ccfg_hit) begin
			rd_mux = ccfg_r[ch_idx];
		end else if (gcfg_hit) begin
			rd_mux = gcfg_r[g_idx];
		end else if (reg_addr == CH_STAT_ADDR) begin
			rd_mux[NCH-1:0] = sovr_r;
		end else if (reg_addr == GEN_STAT_ADDR) begin
			rd_mux[NGEN-1:0] = tovr_r;
		end else if (reg_addr == IRQ_STAT_ADDR) begin
			rd_mux[NIRQ-1:0] = irq_stat_r;
		end else if (reg_addr == IRQ_MASK_ADDR) begin
			rd_mux[NIRQ-1:0] = irq_mask_r;
		end
	end

	// Flags, mask and read data
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sovr_r <= '0;
			tovr_r <= '0;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			rdata_r <= RESET_WORD;
		end else if (ce) begin
			sovr_r <= sovr_nxt;
			tovr_r <= tovr_nxt;
			irq_stat_r <= irq_nxt;
			if (mask_wr) begin
				irq_mask_r <= reg_wdata[NIRQ-1:0];
			end
			rdata_r <= reg_rd ? rd_mux : RESET_WORD;
		end
	end

	// Channels with their configuration words
	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			wire [DATA_W-1:0] w = ccfg_r[c];
			assign ch_cfg_wr[c] = reg_wr && ccfg_hit && (ch_idx == 2'(c));

			// Configuration word with its writable fields only
			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					ccfg_r[c] <= RESET_WORD;
				end else if (ce && ch_cfg_wr[c]) begin
					ccfg_r[c] <= reg_wdata & CCFG_MASK;
				end
			end

			drr_chan u_chan (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.ce(ce),
				.sync_enable(w[SYNC_EN_BIT]),
				.sync_polarity(w[POL_LSB +: POL_W]),
				.request_select(w[REQ_SEL_LSB +: REQ_SEL_W]),
				.sync_input_select(w[SID_LSB +: SID_W]),
				.fwd_count(w[NB_LSB +: NB_W]),
				.cfg_wr(ch_cfg_wr[c]),
				.req_all(req_all),
				.sync_in(sync_in),
				.dma_ack(dma_ack[c]),
				.dma_req(dma_req[c]),
				.served(ch_served[c]),
				.sync_ovr(ch_ovr[c])
			);
		end
	endgenerate

	// Generators; a serve on any channel selecting one acks it
	genvar g;
	generate
		for (g = 0; g < NGEN; g++) begin : g_gen
			wire [DATA_W-1:0] w = gcfg_r[g];
			logic [NCH-1:0] hit;

			for (genvar k = 0; k < NCH; k++) begin : g_ack_or
				assign hit[k] = ch_served[k] &&
					(ccfg_r[k][REQ_SEL_LSB +: REQ_SEL_W] == REQ_SEL_W'(g));
			end
			assign g_ack[g] = |hit;

			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					gcfg_r[g] <= RESET_WORD;
				end else if (ce && reg_wr && gcfg_hit && g_idx == 1'(g)) begin
					gcfg_r[g] <= reg_wdata & GCFG_MASK;
				end
			end

			drr_gen u_gen (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.ce(ce),
				.gen_enable(w[GEN_EN_BIT]),
				.trig_polarity(w[POL_LSB +: POL_W]),
				.trig_select(w[GSEL_LSB +: SID_W]),
				.generated_request_count(w[NB_LSB +: NB_W]),
				.sync_in(sync_in),
				.gen_ack(g_ack[g]),
				.gen_req(g_req[g]),
				.trig_ovr(g_ovr[g])
			);
		end
	endgenerate

	sequence s_clear_idle;
		ce && ch_clr_wr && reg_wdata[0] && !ch_ovr[0];
	endsequence

	AST_SOVR_CLR: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		s_clear_idle |=> !sovr_r[0])
		else $error("sync overrun flag not cleared");
	AST_SOVR_SET: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		ce && ch_clr_wr && ch_ovr[1] |=> sovr_r[1])
		else $error("sync overrun lost during clear");
	AST_TOVR_CLR: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		ce && g_clr_wr && reg_wdata[0] && !g_ovr[0] |=> !tovr_r[0])
		else $error("trigger overrun flag not cleared");
	AST_TOVR_SET: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		ce && g_clr_wr && g_ovr[1] |=> tovr_r[1] && irq_stat_r[NCH+1])
		else $error("trigger overrun lost during clear");
	AST_CFG_KEEP: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		ce && ch_cfg_wr[0] |=> ccfg_r[0] == ($past(reg_wdata) & CCFG_MASK))
		else $error("channel config not stored");
endmodule : drr_top

//--- test/drr_dma_model.sv
// Behavioural DMA controller: serves router requests with one-cycle acks.
// Assumes the router's one clock; stall holds every ack back meanwhile.
`timescale 1ns/1ps
module drr_dma_model
	import drr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic stall,
	input wire logic [NCH-1:0] dma_req,
	output logic [NCH-1:0] dma_ack
);
	// Never two acks in a row, so each ack is one whole served request
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			dma_ack <= '0;
		end else begin
			dma_ack <= dma_req & ~dma_ack & {NCH{~stall}};
		end
	end
endmodule : drr_dma_model

//--- test/test_drr_top.sv
// Self-checking bench for the request router: registers, sync, generators.
// Assumes the DMA model acks at once unless stalled; ce is low only around one write in t_regs.
`timescale 1ns/1ps
module test_drr_top;
	import drr_pkg::*;
	logic core_clk, reset_n, reg_wr, reg_rd, stall, ce;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic [NREQ-1:0] periph_req;
	logic [NSYNC-1:0] sync_in;
	logic [NCH-1:0] dma_req, dma_ack;
	logic irq;
	int n_mismatch, checks, n;

	drr_top i_drr_top(.core_clk(core_clk), .reset_n(reset_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
		.sync_in(sync_in), .dma_req(dma_req), .dma_ack(dma_ack),
		.irq(irq));
	drr_dma_model i_drr_dma_model(.core_clk(core_clk), .reset_n(reset_n),
		.stall(stall), .dma_req(dma_req), .dma_ack(dma_ack));

	// Free-running 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// Optional toggle of one sync line in the very write cycle
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input int t = -1);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		if (t >= 0) sync_in[t] <= ~sync_in[t];
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data is looked at only in the cycle after the strobe
	task automatic rd_chk(input logic [ADDR_W-1:0] a,
		input logic [31:0] e, input string msg);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e, msg);
	endtask : rd_chk

	task automatic tog(input int i);
		@(posedge core_clk);
		sync_in[i] <= ~sync_in[i];
	endtask : tog

	task automatic wait_n(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask : wait_n

	task automatic cnt_ack(input int ch, input int cyc, input int stop);
		n = 0;
		for (int k = 0; k < cyc && n != stop; k++) begin
			@(posedge core_clk);
			#1 if (dma_ack[ch] === 1'b1 && dma_req[ch] === 1'b1) n++;
		end
	endtask : cnt_ack

	function automatic logic [31:0] cfg(input int sel, input bit se,
		input logic [1:0] pol, input int fwd, input int sid);
		cfg = (32'(sel) << REQ_SEL_LSB) | (32'(se) << SYNC_EN_BIT) |
			(32'(pol) << POL_LSB) | (32'(fwd) << NB_LSB) |
			(32'(sid) << SID_LSB);
	endfunction : cfg

	task automatic t_regs;
		rd_chk(CH_STAT_ADDR, 32'h0000_0000, "chan status reset");
		rd_chk(GEN_STAT_ADDR, 32'h0000_0000, "gen status reset");
		rd_chk(12'h0fc, 32'h0000_0000, "unmapped read");
		// A write taken while the clock enable is low must be lost
		ce <= 1'b0;
		wr(IRQ_MASK_ADDR, 32'h0000_003f);
		ce <= 1'b1;
		rd_chk(IRQ_MASK_ADDR, 32'h0000_0000, "write frozen by ce");
		wr(CCFG_BASE + 12'h00c, 32'hffff_ffff);
		rd_chk(CCFG_BASE + 12'h00c, CCFG_MASK, "chan cfg fields");
		wr(CCFG_BASE + 12'h00c, cfg(1, 0, POL_NONE, 0, 0));
		$display("test regs done");
	endtask : t_regs

	task automatic t_pass;
		wr(CCFG_BASE, cfg(5, 0, POL_NONE, 0, 3));
		tog(3);
		@(posedge core_clk);
		periph_req[5] <= 1'b1;
		#1 chk(dma_req[0], 1'b1, "pass through on");
		@(posedge core_clk);
		periph_req[5] <= 1'b0;
		#1 chk(dma_req[0], 1'b0, "pass through off");
		$display("test pass done");
	endtask : t_pass

	// Old input fires two cycles before the write that enables sync
	task automatic t_sel_change;
		stall <= 1'b1;
		wr(CCFG_BASE + 12'h004, cfg(8, 0, POL_BOTH, 0, 11));
		wait_n(2);
		tog(11);
		@(posedge core_clk);
		wr(CCFG_BASE + 12'h004, cfg(9, 1, POL_RISE, 0, 10));
		wait_n(2);
		tog(10);
		periph_req[8] <= 1'b1;
		wait_n(2);
		chk(dma_req[1], 1'b0, "old request routed");
		periph_req[9] <= 1'b1;
		#1 chk(dma_req[1], 1'b1, "new request routed");
		// Let the one ack of the window through before dropping requests
		stall <= 1'b0;
		wait_n(2);
		chk(dma_req[1], 1'b0, "window closed after ack");
		periph_req[9:8] <= 2'h0;
		wait_n(4);
		$display("test select change done");
	endtask : t_sel_change

	task automatic t_sync_ovr;
		stall <= 1'b1;
		periph_req[5] <= 1'b1;
		wr(CCFG_BASE, cfg(5, 1, POL_BOTH, 0, 3));
		wr(CCFG_BASE + 12'h004, cfg(5, 1, POL_BOTH, 0, 4));
		wait_n(2);
		tog(3);
		wait_n(2);
		chk(dma_req, 4'h1, "window ch0 only");
		tog(4);
		wait_n(2);
		tog(3);
		wait_n(2);
		rd_chk(CH_STAT_ADDR, 32'h0000_0001, "ch0 overrun");
		chk(irq, 1'b0, "irq masked");
		wr(CH_CLR_ADDR, 32'h0000_0001, 4);
		wait_n(1);
		rd_chk(CH_STAT_ADDR, 32'h0000_0002, "clear vs ch1 set");
		wr(IRQ_MASK_ADDR, 32'h0000_003f);
		#1 chk(irq, 1'b1, "irq unmasked");
		rd_chk(IRQ_STAT_ADDR, 32'h0000_0003, "irq status");
		wait_n(1);
		chk(irq, 1'b0, "irq after read clear");
		// Both open windows take their ack so none is left for later tests
		stall <= 1'b0;
		wait_n(2);
		chk(dma_req, 4'h0, "windows closed after ack");
		periph_req[5] <= 1'b0;
		wr(CH_CLR_ADDR, 32'h0000_0002);
		rd_chk(CH_STAT_ADDR, 32'h0000_0000, "ch1 cleared");
		$display("test sync overrun done");
	endtask : t_sync_ovr

	task automatic t_gen;
		wr(CCFG_BASE + 12'h008, cfg(0, 0, POL_NONE, 0, 0));
		wr(GCFG_BASE, 32'h1 << GEN_EN_BIT | cfg(6, 0, POL_BOTH, 3, 0));
		wr(GCFG_BASE + 12'h004, 32'h1 << GEN_EN_BIT |
			cfg(7, 0, POL_BOTH, 3, 0));
		tog(6);
		cnt_ack(2, 30, -1);
		chk(n, 4, "burst length");
		tog(6);
		cnt_ack(2, 30, 3);
		@(posedge core_clk);
		tog(6);
		wait_n(4);
		rd_chk(GEN_STAT_ADDR, 32'h0000_0001, "final ack overrun");
		tog(6);
		cnt_ack(2, 30, -1);
		chk(n, 4, "burst after overrun");
		stall <= 1'b1;
		tog(7);
		wait_n(2);
		wr(GEN_CLR_ADDR, 32'h0000_0001, 7);
		wait_n(1);
		rd_chk(GEN_STAT_ADDR, 32'h0000_0002, "clear vs gen1 set");
		stall <= 1'b0;
		wr(GEN_CLR_ADDR, 32'h0000_0002);
		rd_chk(GEN_STAT_ADDR, 32'h0000_0000, "gen1 cleared");
		rd_chk(IRQ_STAT_ADDR, 32'h0000_0030, "gen irq status");
		$display("test generator done");
	endtask : t_gen

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	// Main sequence after a two-cycle reset
	initial begin
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		periph_req = '0;
		sync_in = '0;
		stall = 1'b0;
		ce = 1'b1;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		t_regs();
		t_pass();
		t_sel_change();
		t_sync_ovr();
		t_gen();
		final_report();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end
endmodule : test_drr_top
